// ### pkg/sscl_pkg.sv
// package for the serial setup chain loader: widths, counts and carriers
package sscl_pkg;

  // ****************************************
  // setup word geometry
  // ****************************************
  localparam int unsigned SETUP_BITS  = 64;
  localparam int unsigned CNT_W       = 7;
  localparam logic [6:0]  CNT_FULL    = 7'h40;
  localparam logic [6:0]  CNT_ZERO    = 7'h00;
  localparam logic [63:0] SETUP_RESET = 64'h0000_0000_0000_0000;

  // ****************************************
  // serial pins, before and after synchronising, and the loading state
  // ****************************************
  typedef struct packed {
    logic clk;
    logic data;
    logic enable_n;
  } sscl_serial_t;

  typedef enum logic [0:0] {
    SSCL_LOADING,
    SSCL_DONE
  } sscl_state_t;

endpackage

// ### rtl/sscl_loader.sv
// serial setup chain loader: shift-in, done/enable follow and pass-through
// ****************************************
// ****************************************
`timescale 1ns/1ps
module sscl_loader
(
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic        serial_clk,
  input  wire logic        serial_data_in,
  input  wire logic        serial_load_enable_in,
  input  wire logic        serial_mode_select,
  output      logic        serial_load_done_out,
  output      logic        serial_data_out,
  output      logic        queue_access_ready,
  output      logic [63:0] setup_word
);

  // ****************************************
  // pin synchronising and edge finding
  // ****************************************
  sscl_pkg::sscl_serial_t pins_raw;
  sscl_pkg::sscl_serial_t pins_sync;
  logic                   sclk_prev_reg;
  logic                   sclk_rise;
  logic                   mode_serial_reg;
  logic                   mode_captured_reg;
  logic                   mode_meta_reg;
  logic                   mode_sync_reg;
  logic [1:0]             settle_reg;
  sscl_pkg::sscl_state_t  state_reg;
  logic [6:0]             count_reg;
  logic [63:0]            shift_reg;
  logic                   accept;

  assign pins_raw = '{clk: serial_clk, data: serial_data_in, enable_n: serial_load_enable_in};

  sscl_sync u_sync
  (
    .mclk    (mclk),
    .resetn  (resetn),
    .pin_in  (pins_raw),
    .pin_out (pins_sync)
  );

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      sclk_prev_reg <= 1'b0;
    else
      sclk_prev_reg <= pins_sync.clk;
  end

  assign sclk_rise = pins_sync.clk & ~sclk_prev_reg;

  // ****************************************
  // configuration method, caught after reset release
  // ****************************************
  // strap is a pin like the others, so it crosses two flops first
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      mode_meta_reg <= 1'b0;
      mode_sync_reg <= 1'b0;
    end
    else
    begin
      mode_meta_reg <= serial_mode_select;
      mode_sync_reg <= mode_meta_reg;
    end
  end

  // marks when the strap synchroniser holds a post-reset sample
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      settle_reg <= 2'h0;
    else
      settle_reg <= {settle_reg[0], 1'b1};
  end

  // sampled once; a strap that moves later is ignored on purpose
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      mode_serial_reg   <= 1'b0;
      mode_captured_reg <= 1'b0;
    end
    else if (settle_reg[1] && !mode_captured_reg)
    begin
      mode_serial_reg   <= mode_sync_reg;
      mode_captured_reg <= 1'b1;
    end
  end

  // ****************************************
  // shift register and bit count
  // ****************************************
  // full count refuses a further edge in the cycle before the state moves
  assign accept = sclk_rise && !pins_sync.enable_n && mode_serial_reg
                  && state_reg == sscl_pkg::SSCL_LOADING
                  && count_reg != sscl_pkg::CNT_FULL;

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      shift_reg <= sscl_pkg::SETUP_RESET;
    else if (accept)
      shift_reg <= {shift_reg[62:0], pins_sync.data};
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      count_reg <= sscl_pkg::CNT_ZERO;
    else if (accept)
      count_reg <= count_reg + 7'h01;
  end

  // ****************************************
  // loading state
  // ****************************************
  // default programming finishes as soon as the mode is known
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      state_reg <= sscl_pkg::SSCL_LOADING;
    else
    begin
      unique case (state_reg)
        sscl_pkg::SSCL_LOADING:
          if ((mode_captured_reg && !mode_serial_reg) || count_reg == sscl_pkg::CNT_FULL)
            state_reg <= sscl_pkg::SSCL_DONE;
        sscl_pkg::SSCL_DONE:
          state_reg <= sscl_pkg::SSCL_DONE;
      endcase
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      serial_load_done_out <= 1'b1;
    else if (state_reg == sscl_pkg::SSCL_DONE)
      serial_load_done_out <= pins_sync.enable_n;
    else
      serial_load_done_out <= 1'b1;
  end

  // pass-through is three mclk behind the pin (two sync flops, one output flop); fine at the slow serial rate
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      serial_data_out <= 1'b0;
    else if (state_reg == sscl_pkg::SSCL_DONE && !serial_load_done_out)
      serial_data_out <= pins_sync.data;
    else
      serial_data_out <= 1'b0;
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      queue_access_ready <= 1'b0;
    else if (state_reg == sscl_pkg::SSCL_DONE && !serial_load_done_out)
      queue_access_ready <= 1'b1;
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      setup_word <= sscl_pkg::SETUP_RESET;
    else if (state_reg == sscl_pkg::SSCL_LOADING && count_reg == sscl_pkg::CNT_FULL)
      setup_word <= shift_reg;
  end

  // ****************************************
  // checks
  // ****************************************
  property p_no_shift_when_high;
    @(posedge mclk) disable iff (!resetn)
    pins_sync.enable_n |=> $stable(count_reg);
  endproperty
  a_no_shift_when_high: assert property (p_no_shift_when_high)
    else $error("bit taken while enable high");

  property p_done_high_loading;
    @(posedge mclk) disable iff (!resetn)
    state_reg == sscl_pkg::SSCL_LOADING |=> serial_load_done_out;
  endproperty
  a_done_high_loading: assert property (p_done_high_loading)
    else $error("done low before loading ended");

  property p_done_follows;
    @(posedge mclk) disable iff (!resetn)
    state_reg == sscl_pkg::SSCL_DONE |=> serial_load_done_out == $past(pins_sync.enable_n);
  endproperty
  a_done_follows: assert property (p_done_follows)
    else $error("done does not follow enable");

  property p_ready_after_done;
    @(posedge mclk) disable iff (!resetn)
    $rose(queue_access_ready) |-> $past(serial_load_done_out) == 1'b0;
  endproperty
  a_ready_after_done: assert property (p_ready_after_done)
    else $error("queue access before done low");

  property p_pass_through;
    @(posedge mclk) disable iff (!resetn)
    state_reg == sscl_pkg::SSCL_DONE && !serial_load_done_out
      |=> serial_data_out == $past(pins_sync.data);
  endproperty
  a_pass_through: assert property (p_pass_through)
    else $error("serial data not passed through");

  property p_shift_step;
    @(posedge mclk) disable iff (!resetn)
    accept |=> shift_reg[0] == $past(pins_sync.data) && count_reg == $past(count_reg) + 7'h01;
  endproperty
  a_shift_step: assert property (p_shift_step)
    else $error("shift register did not advance");

  property p_mode_gate;
    @(posedge mclk) disable iff (!resetn)
    mode_captured_reg && !mode_serial_reg |=> $stable(shift_reg);
  endproperty
  a_mode_gate: assert property (p_mode_gate)
    else $error("shifting without serial mode");

  property p_full_count;
    @(posedge mclk) disable iff (!resetn)
    state_reg == sscl_pkg::SSCL_LOADING && count_reg == sscl_pkg::CNT_FULL
      |=> state_reg == sscl_pkg::SSCL_DONE;
  endproperty
  a_full_count: assert property (p_full_count)
    else $error("loading not done at full count");

endmodule

// ### rtl/sscl_sync.sv
// two-flop synchroniser for the serial pins
`timescale 1ns/1ps
module sscl_sync
(
  input  wire logic                  mclk,
  input  wire logic                  resetn,
  input  wire sscl_pkg::sscl_serial_t pin_in,
  output      sscl_pkg::sscl_serial_t pin_out
);

  sscl_pkg::sscl_serial_t meta_reg;
  sscl_pkg::sscl_serial_t sync_reg;

  // enable idles high so the loader never sees a false start
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      meta_reg <= '{clk: 1'b0, data: 1'b0, enable_n: 1'b1};
      sync_reg <= '{clk: 1'b0, data: 1'b0, enable_n: 1'b1};
    end
    else
    begin
      meta_reg <= pin_in;
      sync_reg <= meta_reg;
    end
  end

  assign pin_out = sync_reg;

endmodule

// ### verif/serial_setup_chain_loader_tb_top.sv
// self-checking bench for the serial setup chain loader
`timescale 1ns/1ps
module serial_setup_chain_loader_tb_top;
  logic        mclk = 1'b0;
  logic        resetn = 1'b0;
  logic        mode = 1'b1;
  logic        sclk;
  logic        sdata;
  logic        en_n;
  logic        done_n;
  logic        sout;
  logic        ready;
  logic [63:0] setup_word;
  logic [63:0] word;
  logic [63:0] loaded;
  int          bad_count = 0;
  int          samples_checked = 0;

  always #5 mclk = ~mclk;

  sscl_host i_host
  (
    .mclk     (mclk),
    .sclk     (sclk),
    .sdata    (sdata),
    .enable_n (en_n)
  );

  sscl_loader i_dut
  (
    .mclk                  (mclk),
    .resetn                (resetn),
    .serial_clk            (sclk),
    .serial_data_in        (sdata),
    .serial_load_enable_in (en_n),
    .serial_mode_select    (mode),
    .serial_load_done_out  (done_n),
    .serial_data_out       (sout),
    .queue_access_ready    (ready),
    .setup_word            (setup_word)
  );

  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // done tracks enable within a few cycles, so the wait is short
  task automatic wait_done(input logic v);
    for (int i = 0; i < 20 && done_n !== v; i++)
      @(posedge mclk);
    check("done", done_n, v);
  endtask

  task automatic do_reset(input logic m);
    resetn <= 1'b0;
    mode <= m;
    repeat (20) @(posedge mclk);
    resetn <= 1'b1;
    repeat (3) @(posedge mclk);
  endtask

  task automatic wrap_up;
    $display("checked %0d, wrong %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    void'($urandom(32'hc788));
    word = {$urandom, $urandom};
    do_reset(1'b1);
    i_host.shift(word, 64);
    repeat (8) @(posedge mclk);
    check("word idle", setup_word, 64'h0000_0000_0000_0000);
    check("done idle", done_n, 1'b1);
    $display("test ignore ended");
    i_host.set_enable(1'b0);
    i_host.shift(word, 63);
    repeat (8) @(posedge mclk);
    check("done early", done_n, 1'b1);
    check("ready early", ready, 1'b0);
    i_host.shift({word[0], 63'h0}, 1);
    wait_done(1'b0);
    repeat (3) @(posedge mclk);
    check("word", setup_word, word);
    check("ready", ready, 1'b1);
    loaded = word;
    $display("test load ended");
    word = {$urandom, $urandom};
    fork
      i_host.shift(word, 16);
      for (int i = 0; i < 16; i++)
      begin
        repeat (8) @(posedge mclk);
        check("pass", sout, word[63-i]);
      end
    join
    check("word held", setup_word, loaded);
    i_host.set_enable(1'b1);
    wait_done(1'b1);
    i_host.set_enable(1'b0);
    wait_done(1'b0);
    check("ready sticky", ready, 1'b1);
    $display("test pass ended");
    do_reset(1'b0);
    wait_done(1'b0);
    i_host.shift(word, 64);
    check("word default", setup_word, 64'h0000_0000_0000_0000);
    i_host.set_enable(1'b1);
    wait_done(1'b1);
    $display("test default ended");
    wrap_up();
  end

  // tests need about 2,000 cycles; allow several times that
  initial
  begin
    #100000;
    bad_count++;
    wrap_up();
  end
endmodule

// ### verif/sscl_host.sv
// host controller model driving the loader's serial setup link
`timescale 1ns/1ps
module sscl_host
(
  input  wire logic mclk,
  output      logic sclk,
  output      logic sdata,
  output      logic enable_n
);
  initial
  begin
    sclk = 1'b0;
    sdata = 1'b0;
    enable_n = 1'b1;
  end

  // 4 mclk per half gives the 80 ns bit time, data steady around the rise
  task automatic shift(input logic [63:0] w, input int n);
    for (int i = 0; i < n; i++)
    begin
      sdata <= w[63-i];
      repeat (4) @(posedge mclk);
      sclk <= 1'b1;
      repeat (4) @(posedge mclk);
      sclk <= 1'b0;
    end
    // released line flips so a stale bit cannot pass for a live one
    sdata <= ~w[64-n];
  endtask

  task automatic set_enable(input logic v);
    enable_n <= v;
    @(posedge mclk);
  endtask
endmodule
